// [typec_port_general_control.sv]
`timescale 1ns/1ps
`default_nettype none
`include "typec_params.svh"

// Overview of operation
// - debounce field picks CC debounce time
// - mode field picks DRP, UFP or DFP
// - mode field used only with I2C strap
// - soft reset bit starts reset, self-clears
// - soft reset returns status fields to defaults
// - preference field selects Try.SNK or Try.SRC
// - termination disable removes CC terminations
// - general control at 0x0A, resets 0x00
// - read-only revision register at 0xA0
// - interrupt output spares host from polling
// - advertise and detect 900mA, 1.5A, 3A
// - status change sets sticky interrupt bit
// - attach state encodes none, src, snk, acc
module typec_port_general_control import typec_pkg::*; #(
  parameter int DEB00_CYC = `DEB00_MS * `CLK_KHZ,
  parameter int DEB01_CYC = `DEB01_MS * `CLK_KHZ,
  parameter int DEB10_CYC = `DEB10_MS * `CLK_KHZ,
  parameter int DEB11_CYC = `DEB11_MS * `CLK_KHZ,
  parameter logic [7:0] REVISION = `REVISION_VAL
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic int_n_o,
  // strap and role pins
  input wire logic addr_i2c_i,
  input wire logic [1:0] port_pin_i,
  // cc logic side
  input wire conn_status_type cc_status_i,
  output port_ctrl_type port_ctrl_o,
  output logic cc_logic_rst_o
);

  localparam int SRST_N = `SRST_CYC;

  reg_req_type req;
  logic [7:0] rdata;
  logic [1:0] strap_m_q;
  logic [3:0] pin_m_q;
  logic gen_wr, stat_wr, ctrl_wr, busy;

  logic [7:0] gen_q, gen_d;
  logic [1:0] adv_q, adv_d, duty_q, duty_d;
  logic ufpacc_q, ufpacc_d;
  logic [4:0] srst_q, srst_d;
  conn_status_type cand_q, cand_d, status_q, status_d;
  logic [23:0] deb_q, deb_d;
  logic int_q, int_d;
  role_mode_type mode_q, mode_d, mode_req;
  port_ctrl_type ctrl_q, ctrl_d;

  i2c_reg_target u_i2c (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .req_o(req),
    .rdata_i(rdata)
  );

  function automatic logic [23:0] deb_limit(input logic [1:0] sel);
    case (sel)
      2'h0: deb_limit = 24'(DEB00_CYC);
      2'h1: deb_limit = 24'(DEB01_CYC);
      2'h2: deb_limit = 24'(DEB10_CYC);
      default: deb_limit = 24'(DEB11_CYC);
    endcase
  endfunction

  // strap and role pins come from outside the clock domain
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      strap_m_q <= 2'h0;
      pin_m_q <= 4'h0;
    end else begin
      strap_m_q <= {strap_m_q[0], addr_i2c_i};
      pin_m_q <= {pin_m_q[1:0], port_pin_i};
    end
  end

  assign gen_wr = req.wr && req.addr == `OFS_GEN_CTRL;
  assign stat_wr = req.wr && req.addr == `OFS_CONN_STATUS;
  assign ctrl_wr = req.wr && req.addr == `OFS_CONN_CTRL;
  assign busy = srst_q != 5'h00;

  // read mux; revision ignores writes
  always_comb begin
    case (req.addr)
      `OFS_CONN_STATUS: rdata = {adv_q, status_q.cur_detect,
                                 status_q.accessory,
                                 status_q.active_cable_flag};
      `OFS_CONN_CTRL: rdata = {status_q.attach, status_q.cable_dir,
                               int_q, 1'b0, duty_q, ufpacc_q};
      `OFS_GEN_CTRL: rdata = {gen_q[7:4], busy, gen_q[2:0]};
      `OFS_REVISION: rdata = REVISION;
      default: rdata = 8'h00;
    endcase
  end

  // control registers
  always_comb begin
    gen_d = gen_q;
    adv_d = adv_q;
    duty_d = duty_q;
    ufpacc_d = ufpacc_q;
    srst_d = busy ? srst_q - 5'h01 : srst_q;
    // all fields writable but soft reset
    if (gen_wr) begin
      gen_d = req.wdata;
      gen_d[`GC_SRST_BIT] = 1'b0;
    end
    // start reset, retrigger ignored while busy
    if (gen_wr && req.wdata[`GC_SRST_BIT] && !busy) begin
      srst_d = 5'(SRST_N);
    end
    if (stat_wr) begin
      adv_d = req.wdata[7:6];
    end
    if (ctrl_wr) begin
      duty_d = req.wdata[`CC_DUTY_LSB +: 2];
      ufpacc_d = req.wdata[`CC_UFPACC_BIT];
    end
  end

  // status capture, debounce and interrupt
  always_comb begin
    cand_d = cc_status_i;
    status_d = status_q;
    deb_d = deb_q;
    // input must hold for the chosen time
    if (cc_status_i != cand_q) begin
      deb_d = 24'h000000;
    end else if (deb_q + 24'h000001 >= deb_limit(gen_q[7:6])) begin
      status_d = cand_q;
    end else begin
      deb_d = deb_q + 24'h000001;
    end
    // status held at defaults during soft reset
    if (busy) begin
      status_d = `CONN_STATUS_RST;
      deb_d = 24'h000000;
    end
    int_d = int_q;
    if (ctrl_wr && req.wdata[`CC_INT_BIT]) begin
      int_d = 1'b0;
    end
    if (status_d != status_q) begin
      int_d = 1'b1;
    end
  end

  // role and port control
  always_comb begin
    // field only when strapped for i2c and non-default
    if (strap_m_q[1] && gen_q[5:4] != 2'h0) begin
      mode_req = role_mode_type'(gen_q[5:4]);
    end else begin
      mode_req = role_mode_type'(pin_m_q[3:2]);
    end
    mode_d = mode_q;
    if (status_q.attach == 2'h0) begin
      mode_d = mode_req;
    end
    ctrl_d.mode = mode_q;
    // try behaviour only as dual role
    ctrl_d.try_snk = (mode_q == ROLE_DRP || mode_q == ROLE_DRP_ALT) &&
                     gen_q[2:1] == 2'h1;
    ctrl_d.try_src = (mode_q == ROLE_DRP || mode_q == ROLE_DRP_ALT) &&
                     gen_q[2:1] == 2'h3;
    ctrl_d.term_en = !gen_q[`GC_DTERM_BIT];
    ctrl_d.cc_disable = gen_q[`GC_DTERM_BIT];
    ctrl_d.cur_adv = adv_q;
    ctrl_d.drp_duty = duty_q;
    ctrl_d.ufp_acc_dis = ufpacc_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gen_q <= `GEN_CTRL_RST;
      adv_q <= 2'h0;
      duty_q <= 2'h0;
      ufpacc_q <= 1'b0;
      srst_q <= 5'h00;
      cand_q <= `CONN_STATUS_RST;
      status_q <= `CONN_STATUS_RST;
      deb_q <= 24'h000000;
      int_q <= 1'b0;
      mode_q <= ROLE_DRP;
      ctrl_q <= '0;
    end else begin
      gen_q <= gen_d;
      adv_q <= adv_d;
      duty_q <= duty_d;
      ufpacc_q <= ufpacc_d;
      srst_q <= srst_d;
      cand_q <= cand_d;
      status_q <= status_d;
      deb_q <= deb_d;
      int_q <= int_d;
      mode_q <= mode_d;
      ctrl_q <= ctrl_d;
    end
  end

  // open-drain style interrupt, low while pending
  assign int_n_o = !int_q;
  assign port_ctrl_o = ctrl_q;
  assign cc_logic_rst_o = busy;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence srst_start;
    gen_wr && req.wdata[`GC_SRST_BIT] && !busy;
  endsequence

  sequence srst_window;
    busy ##[SRST_N:SRST_N] !busy;
  endsequence

  a_srst_self_clear: assert property (
    srst_start |=> srst_window)
    else $error("soft reset did not self clear on time");

  a_srst_readback: assert property (
    busy && req.addr == `OFS_GEN_CTRL |-> rdata[`GC_SRST_BIT])
    else $error("soft reset bit not read as one while busy");

  a_srst_status: assert property (
    busy |=> status_q == `CONN_STATUS_RST)
    else $error("status not at default during soft reset");

  a_int_on_change: assert property (
    $changed(status_q) |-> int_q && !int_n_o)
    else $error("status change did not raise interrupt");

  a_int_sticky: assert property (
    int_q && !(ctrl_wr && req.wdata[`CC_INT_BIT]) |=> int_q)
    else $error("interrupt bit dropped without clear");

  a_mode_locked: assert property (
    status_q.attach != 2'h0 |=> $stable(mode_q))
    else $error("role changed while attached");

  a_term_disable: assert property (
    gen_q[`GC_DTERM_BIT] |=> ctrl_q.cc_disable && !ctrl_q.term_en)
    else $error("terminations not removed");

  a_try_drp_only: assert property (
    ctrl_q.try_snk || ctrl_q.try_src |->
      $past(mode_q) inside {ROLE_DRP, ROLE_DRP_ALT})
    else $error("try behaviour outside dual role");

  a_rev_read: assert property (
    req.addr == `OFS_REVISION |-> rdata == REVISION)
    else $error("revision register read wrong");

  a_deb_restart: assert property (
    !busy && cc_status_i != cand_q |=> deb_q == 24'h000000 &&
      $stable(status_q))
    else $error("debounce did not restart on input change");

endmodule

`default_nettype wire

// [typec_params.svh]
`ifndef TYPEC_PARAMS_SVH
`define TYPEC_PARAMS_SVH

// register offsets
`define OFS_CONN_STATUS 8'h08
`define OFS_CONN_CTRL 8'h09
`define OFS_GEN_CTRL 8'h0a
`define OFS_REVISION 8'ha0

// general control field positions
`define GC_DEB_LSB 6
`define GC_MODE_LSB 4
`define GC_SRST_BIT 3
`define GC_PREF_LSB 1
`define GC_DTERM_BIT 0
// connection control field positions
`define CC_INT_BIT 4
`define CC_DUTY_LSB 1
`define CC_UFPACC_BIT 0

// reset values
`define GEN_CTRL_RST 8'h00
`define CONN_STATUS_RST 9'h001
// revision code, arbitrary
`define REVISION_VAL 8'h5a

// timing
`define CLK_KHZ 50000
`define DEB00_MS 168
`define DEB01_MS 118
`define DEB10_MS 134
`define DEB11_MS 152
`define SRST_CYC 16

// i2c target address, arbitrary
`define I2C_DEV_ADDR 7'h47

`endif

// [typec_pkg.sv]
package typec_pkg;

  typedef struct packed {
    logic [1:0] cur_detect;
    logic active_cable_flag;
    logic [2:0] accessory;
    logic [1:0] attach;
    logic cable_dir;
  } conn_status_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef enum logic [1:0] {
    ROLE_DRP = 2'h0,
    ROLE_UFP = 2'h1,
    ROLE_DFP = 2'h2,
    ROLE_DRP_ALT = 2'h3
  } role_mode_type;

  typedef struct packed {
    role_mode_type mode;
    logic try_snk;
    logic try_src;
    logic term_en;
    logic cc_disable;
    logic [1:0] cur_adv;
    logic [1:0] drp_duty;
    logic ufp_acc_dis;
  } port_ctrl_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DEV = 5'h02,
    ST_PTR = 5'h04,
    ST_WR = 5'h08,
    ST_RD = 5'h10
  } i2c_state_type;

endpackage

// [i2c_reg_target.sv]
`timescale 1ns/1ps
`default_nettype none
`include "typec_params.svh"

module i2c_reg_target import typec_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = `I2C_DEV_ADDR
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // i2c pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // register side
  output reg_req_type req_o,
  input wire logic [7:0] rdata_i
);

  logic [1:0] scl_m_q, sda_m_q;
  logic scl_p_q, sda_p_q;
  logic start, stop, rise, fall;
  i2c_state_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic rw_q, rw_d, oe_q, oe_d;
  reg_req_type req_q, req_d;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      scl_m_q <= 2'h3;
      sda_m_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_m_q <= {scl_m_q[0], scl_i};
      sda_m_q <= {sda_m_q[0], sda_i};
      scl_p_q <= scl_m_q[1];
      sda_p_q <= sda_m_q[1];
    end
  end

  assign start = scl_m_q[1] & sda_p_q & ~sda_m_q[1];
  assign stop = scl_m_q[1] & ~sda_p_q & sda_m_q[1];
  assign rise = scl_m_q[1] & ~scl_p_q;
  assign fall = ~scl_m_q[1] & scl_p_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    oe_d = oe_q;
    req_d = '0;
    req_d.addr = ptr_q;
    req_d.wdata = sh_q;
    if (start) begin
      st_d = ST_DEV;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop) begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (rise) begin
      if (st_q == ST_RD) begin
        if (cnt_q < 4'h8) begin
          cnt_d = cnt_q + 4'h1;
        end else if (sda_m_q[1]) begin
          // master nack ends the read
          st_d = ST_IDLE;
        end
      end else if (st_q != ST_IDLE && cnt_q < 4'h8) begin
        sh_d = {sh_q[6:0], sda_m_q[1]};
        cnt_d = cnt_q + 4'h1;
      end
    end else if (fall) begin
      if (st_q == ST_RD) begin
        if (cnt_q == 4'h8) begin
          oe_d = 1'b0;
          cnt_d = 4'h9;
        end else if (cnt_q == 4'h9) begin
          cnt_d = 4'h0;
          sh_d = rdata_i;
          oe_d = ~rdata_i[7];
          req_d.rd = 1'b1;
          ptr_d = ptr_q + 8'h01;
        end else if (cnt_q != 4'h0) begin
          sh_d = {sh_q[6:0], 1'b1};
          oe_d = ~sh_q[6];
        end
      end else if (st_q != ST_IDLE && cnt_q == 4'h8) begin
        cnt_d = 4'h9;
        oe_d = 1'b1;
        case (st_q)
          ST_DEV: begin
            rw_d = sh_q[0];
            if (sh_q[7:1] != DEV_ADDR) begin
              st_d = ST_IDLE;
              oe_d = 1'b0;
            end
          end
          ST_PTR: ptr_d = sh_q;
          ST_WR: req_d.wr = 1'b1;
          default: ;
        endcase
      end else if (st_q != ST_IDLE && cnt_q == 4'h9) begin
        cnt_d = 4'h0;
        oe_d = 1'b0;
        case (st_q)
          ST_DEV: begin
            if (rw_q) begin
              st_d = ST_RD;
              sh_d = rdata_i;
              oe_d = ~rdata_i[7];
              req_d.rd = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end else begin
              st_d = ST_PTR;
            end
          end
          ST_PTR: st_d = ST_WR;
          ST_WR: ptr_d = ptr_q + 8'h01;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign req_o = req_q;

endmodule

`default_nettype wire

// [i2c_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "typec_params.svh"

module i2c_host_model #(
  parameter logic [6:0] DEV = `I2C_DEV_ADDR,
  parameter int HALF = 10
) (
  // clock
  input wire logic ref_clk_i,
  // i2c lines
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic sda_q = 1'b1;
  int extra = 0;

  initial scl_o = 1'b1;
  // pull-up: line low while either side pulls
  assign sda_o = sda_q & ~sda_oe_i;

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // data moves mid low phase, away from both scl edges
  task automatic put_bit(input logic b, output logic seen);
    hold(HALF / 2);
    sda_q <= b;
    hold(HALF / 2);
    scl_o <= 1'b1;
    hold(HALF + extra);
    seen = sda_o;
    scl_o <= 1'b0;
  endtask

  task automatic start_cond();
    @(posedge ref_clk_i);
    sda_q <= 1'b0;
    hold(HALF);
    scl_o <= 1'b0;
  endtask

  task automatic end_cond(input logic lvl);
    hold(HALF / 2);
    sda_q <= lvl;
    hold(HALF / 2);
    scl_o <= 1'b1;
    hold(HALF);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           input logic [7:0] val, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(ofs, a1);
    send_byte(val, a2);
    end_cond(1'b0);
    sda_q <= 1'b1;
    hold(HALF);
    ack = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val);
    logic a;
    logic s;
    start_cond();
    send_byte({DEV, 1'b0}, a);
    send_byte(ofs, a);
    end_cond(1'b1);
    start_cond();
    send_byte({DEV, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      val[i] = s;
    end
    // nack ends the read
    put_bit(1'b1, s);
    end_cond(1'b0);
    sda_q <= 1'b1;
    hold(HALF);
  endtask
endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "typec_params.svh"

module tb_top import typec_pkg::*;;
  localparam logic [7:0] REV_CODE = 8'h3c; // arbitrary value
  localparam int DEB [4] = '{80, 56, 64, 72};
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic scl, sda, sda_o, sda_oe, int_n, srst, a, drp;
  logic addr_i2c = 1'b1;
  logic [1:0] port_pin = 2'h0;
  logic [1:0] em;
  conn_status_type cc_st = 9'h001;
  port_ctrl_type pc;
  int error_cnt = 0;
  int compares = 0;
  int n;
  string nm_q[$];
  logic [15:0] exp_q[$];
  logic [15:0] seen_v;
  logic [15:0] rnd = 16'h6da2;
  event seen_ev;

  typec_port_general_control #(
    .DEB00_CYC(DEB[0]), .DEB01_CYC(DEB[1]), .DEB10_CYC(DEB[2]),
    .DEB11_CYC(DEB[3]), .REVISION(REV_CODE)
  ) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .int_n_o(int_n),
    .addr_i2c_i(addr_i2c), .port_pin_i(port_pin), .cc_status_i(cc_st),
    .port_ctrl_o(pc), .cc_logic_rst_o(srst)
  );

  i2c_host_model i_host (
    .ref_clk_i(ref_clk_i), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda)
  );

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic note(input string nm, input logic [15:0] exp);
    nm_q.push_back(nm);
    exp_q.push_back(exp);
  endtask

  task automatic show(input logic [15:0] v);
    seen_v = v;
    ->seen_ev;
    #1;
  endtask

  task automatic pin(input string nm, input logic [15:0] exp,
                     input logic [15:0] v);
    note(nm, exp);
    show(v);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [7:0] val);
    logic ack;
    i_host.write_reg(`I2C_DEV_ADDR, ofs, val, ack);
  endtask

  task automatic rd(input string nm, input logic [7:0] ofs,
                    input logic [7:0] exp);
    logic [7:0] v;
    note(nm, {8'h00, exp});
    i_host.read_reg(ofs, v);
    show({8'h00, v});
  endtask

  // the oldest note pairs with each result shown
  initial begin
    forever begin
      @(seen_ev);
      check(nm_q.pop_front(), seen_v, exp_q.pop_front());
    end
  end

  initial begin
    // tests need roughly 54k cycles; stop at 90k
    cyc(90000);
    error_cnt++;
    give_verdict();
  end

  initial begin
    cyc(12);
    rst_i <= 1'b0;
    cyc(8);
    rd("gen_ctrl", 8'h0a, 8'h00);
    wr(8'ha0, 8'hff);
    rd("revision", 8'ha0, REV_CODE);
    rd("unmapped", 8'h55, 8'h00);
    pin("term_en", 16'h1, pc.term_en);
    i_host.write_reg(7'h12, 8'h0a, 8'h30, a);
    pin("bad_addr_ack", 16'h0, a);
    for (int d = 0; d < 4; d++) begin
      wr(8'h0a, {d[1:0], 6'h00});
      wr(8'h09, 8'h10);
      cyc(4);
      pin("int_clear", 16'h1, int_n);
      cc_st.active_cable_flag <= ~cc_st.active_cable_flag;
      cyc(DEB[d] - 3);
      pin("int_early", 16'h1, int_n);
      cyc(7);
      pin("int_late", 16'h0, int_n);
      rd("status", 8'h08, {7'h00, cc_st.active_cable_flag});
    end
    // every mode and preference, slow host
    i_host.extra = 15;
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      port_pin <= rnd[1:0];
      addr_i2c <= rnd[2];
      wr(8'h0a, {2'b00, i[3:2], 1'b0, i[1:0], 1'b0});
      cyc(8);
      em = (rnd[2] && i[3:2] != 2'b00) ? i[3:2] : rnd[1:0];
      drp = em[1] == em[0];
      pin("mode", {14'h0, em}, pc.mode);
      pin("try_snk", {15'h0, drp && i[1:0] == 2'b01}, pc.try_snk);
      pin("try_src", {15'h0, drp && i[1:0] == 2'b11}, pc.try_src);
      rd("gen_rw", 8'h0a, {2'b00, i[3:2], 1'b0, i[1:0], 1'b0});
    end
    i_host.extra = 0;
    wr(8'h0a, 8'h01);
    cyc(8);
    pin("cc_disable", 16'h1, pc.cc_disable);
    pin("term_off", 16'h0, pc.term_en);
    wr(8'h08, 8'h80);
    cyc(8);
    pin("cur_adv", 16'h2, pc.cur_adv);
    addr_i2c <= 1'b1;
    wr(8'h0a, 8'h10);
    cyc(8);
    pin("mode_ufp", 16'h1, pc.mode);
    cc_st.attach <= 2'b10;
    cyc(DEB[0] + 10);
    rd("attach", 8'h09, 8'hb0);
    wr(8'h0a, 8'h20);
    cyc(8);
    pin("mode_held", 16'h1, pc.mode);
    cc_st.attach <= 2'b00;
    cyc(DEB[0] + 10);
    pin("mode_new", 16'h2, pc.mode);
    // soft reset pulse and side effects
    cc_st.accessory <= 3'b100;
    cyc(DEB[0] + 10);
    wr(8'h09, 8'h10);
    cyc(4);
    fork
      wr(8'h0a, 8'h68);
      begin
        wait (srst === 1'b1);
        // count on falling edges, away from the launching edge
        @(negedge ref_clk_i);
        n = 0;
        while (srst === 1'b1) begin
          n++;
          @(negedge ref_clk_i);
        end
      end
    join
    pin("srst_len", `SRST_CYC, n[15:0]);
    pin("int_srst", 16'h0, int_n);
    rd("srst_clear", 8'h0a, 8'h60);
    give_verdict();
  end
endmodule

`default_nettype wire
